// file: hw/pws_pkg.sv
// Shared constants for the posted write request stream framer.
package pws_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int DATA_W     = 256;  // Request data width
  localparam int KEEP_W     = 32;   // One keep bit per byte
  localparam int USER_W     = 60;   // Sideband width
  localparam int DW_PER_BT  = 8;    // Dwords per beat
  localparam int FIFO_DEPTH = 32;   // Payload buffer words
  localparam int LEN_W      = 9;    // Dword count 1..256
  localparam int CNT_W      = 6;    // Beat and word counters
  localparam int LVL_W      = 6;    // Fifo level 0..32

  // ----------------------------------------------------------------
  // Descriptor field positions (first beat, low 128 bits)
  // ----------------------------------------------------------------
  localparam int DESC_ADDR_LSB = 2;   // Dword address 63:2
  localparam int DESC_DW_LSB   = 64;  // Dword count 74:64
  localparam int DESC_DW_W     = 11;
  localparam int DESC_TYPE_LSB = 75;  // Request type 78:75
  localparam int DESC_TAG_LSB  = 96;  // Tag 103:96
  localparam logic [3:0] REQ_MEM_WRITE = 4'h1;

  // ----------------------------------------------------------------
  // Sideband field positions
  // ----------------------------------------------------------------
  localparam int USR_HEAD_BE_LSB = 0;   // Head byte enables 3:0
  localparam int USR_TAIL_BE_LSB = 4;   // Tail byte enables 7:4
  localparam int USR_OFF_LSB     = 8;   // Start offset 10:8
  localparam int USR_ABORT_BIT   = 11;  // Nullify request
  localparam logic [3:0] BE_ALL  = 4'hF;

  // ----------------------------------------------------------------
  // Reset values and states
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_DATA = '0;
  localparam logic [KEEP_W-1:0] RST_KEEP = '0;
  localparam logic [USER_W-1:0] RST_USER = '0;

  typedef enum logic [1:0] {
    PWS_IDLE = 2'b00,  // Waiting for a command
    PWS_DESC = 2'b01,  // Waiting to emit descriptor
    PWS_PAY  = 2'b10   // Emitting payload beats
  } pws_state_t;

endpackage : pws_pkg

// file: hw/pws_fifo.sv
// Payload buffer with valid/ready on both sides and a fill level.
module pws_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic [WIDTH-1:0]           inData,
  input  wire logic                       inValid,
  output logic                            inReady,
  output logic [WIDTH-1:0]                outData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  import pws_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] wrPtr;  // Next slot to fill
    logic [AW-1:0] rdPtr;  // Head slot
    logic [LW-1:0] count;  // Words held
    logic          notFull;  // Registered room flag
  } pws_fifo_st_t;

  pws_fifo_st_t         st;       // Registered pointers
  pws_fifo_st_t         next_st;  // Next pointers
  logic [WIDTH-1:0]     mem [DEPTH];  // Storage array
  logic                 push;     // Write handshake
  logic                 pop;      // Read handshake

  // Room flag is registered so the write side sees a flop output
  assign inReady  = st.notFull;
  assign outValid = (st.count != '0);
  assign outData  = mem[st.rdPtr];
  assign level    = st.count;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer update, wrapping at depth
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wrPtr = (st.wrPtr == AW'(DEPTH-1)) ? '0 : st.wrPtr + 1'b1;
    end
    if (pop) begin
      next_st.rdPtr = (st.rdPtr == AW'(DEPTH-1)) ? '0 : st.rdPtr + 1'b1;
    end
    // Push and pop together leave the count alone
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    // Room worked out a cycle ahead of its use
    next_st.notFull = (next_st.count != LW'(DEPTH));
  end

  // Register pointers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '{wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[st.wrPtr] <= inData;
    end
  end

endmodule : pws_fifo

// file: hw/pws_framer.sv
// Framer that turns write commands and payload into aligned requests.
module pws_framer (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // Command side
  input  wire logic                          cmdValid,
  output logic                               cmdReady,
  input  wire logic [63:0]                   cmdAddr,
  input  wire logic [pws_pkg::LEN_W-1:0]     cmdDwords,
  input  wire logic [7:0]                    cmdTag,
  input  wire logic                          abortReq,
  // Payload side
  input  wire logic [pws_pkg::DATA_W-1:0]    wrData,
  input  wire logic                          wrValid,
  output logic                               wrReady,
  // Request stream to the partner
  output logic [pws_pkg::DATA_W-1:0]         requestDataBus,
  output logic                               requestLastBeat,
  output logic                               requestValidOut,
  output logic [pws_pkg::USER_W-1:0]         requestSideband,
  output logic [pws_pkg::KEEP_W-1:0]         requestLaneKeep,
  input  wire logic                          requestReadyIn
);
  import pws_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pws_state_t         state;      // Framer phase
    logic               cmdReady;   // Command slot open
    logic [63:0]        addr;       // Target address
    logic [LEN_W-1:0]   dwords;     // Payload length
    logic [7:0]         tag;        // Request tag
    logic [2:0]         off;        // Payload start dword
    logic [CNT_W-1:0]   wordsLeft;  // Fifo words still to pop
    logic [CNT_W-1:0]   beatsLeft;  // Payload beats still to send
    logic [3:0]         lastDw;     // Dwords in final beat
    logic               abortSeen;  // Abort caught this packet
    logic [DATA_W-1:0]  carry;      // Previous payload word
    logic [DATA_W-1:0]  data;       // Output beat data
    logic [KEEP_W-1:0]  keep;       // Output keep
    logic               last;       // Output last
    logic               valid;      // Output valid
    logic [USER_W-1:0]  user;       // Output sideband
  } pws_st_t;

  pws_st_t            st;           // Registered state
  pws_st_t            next_st;      // Next state
  logic [DATA_W-1:0]  fifoData;     // Head payload word
  logic               fifoValid;    // Head present
  logic               fifoPop;      // Pop strobe
  logic [LVL_W-1:0]   fifoLevel;    // Words buffered
  logic [KEEP_W-1:0]  lastKeepMask; // Keep for the final beat
  logic               slotFree;     // Output register can load

  // ----------------------------------------------------------------
  // Payload buffer
  // ----------------------------------------------------------------
  pws_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   (wrData),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .level    (fifoLevel)
  );

  // ----------------------------------------------------------------
  // Final-beat keep mask, one bit per byte lane
  // ----------------------------------------------------------------
  // contiguous keep lanes
  for (genvar i = 0; i < KEEP_W; i++) begin : g_keep
    assign lastKeepMask[i] = (st.lastDw > 4'(i / 4));
  end

  // beat moves on valid and ready
  assign slotFree = !st.valid || requestReadyIn;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [2*DATA_W-1:0] pair;      // Current word over carry
    logic [8:0]          shiftAmt;  // Bits to drop from pair
    logic [DATA_W-1:0]   word;      // Word feeding this beat
    logic [USER_W-1:0]   side;      // Sideband for a new beat
    logic [9:0]          span;      // Offset plus length
    logic [CNT_W-1:0]    needWords; // Words the packet needs
    pair      = '0;
    shiftAmt  = '0;
    word      = '0;
    side      = '0;
    span      = '0;
    needWords = '0;
    next_st   = st;
    fifoPop   = 1'b0;

    // stalled beat kept as is
    // A taken beat leaves the register empty until refilled; a
    // stalled one is left alone so the partner never sees it tear.
    if (slotFree) begin
      next_st.valid = 1'b0;
      next_st.last  = 1'b0;
    end

    // abort sticks for the rest of the packet
    if (st.state != PWS_IDLE && abortReq) begin
      next_st.abortSeen = 1'b1;
    end

    // Sideband for any beat loaded this cycle
    // byte enables all ones
    side[USR_HEAD_BE_LSB +: 4] = BE_ALL;
    side[USR_TAIL_BE_LSB +: 4] = BE_ALL;
    side[USR_OFF_LSB +: 3]     = st.off;
    side[USR_ABORT_BIT]        = st.abortSeen || abortReq;
    // parity and hint bits stay zero

    needWords = CNT_W'((st.dwords + LEN_W'(DW_PER_BT - 1)) >> 3);

    case (st.state)
      // Accept one command, then freeze the slot
      PWS_IDLE: begin
        next_st.cmdReady = 1'b1;
        if (cmdValid && st.cmdReady) begin
          next_st.cmdReady  = 1'b0;
          next_st.addr      = cmdAddr;
          next_st.dwords    = cmdDwords;
          next_st.tag       = cmdTag;
          next_st.off       = cmdAddr[4:2];
          next_st.abortSeen = abortReq;
          span = 10'(cmdAddr[4:2]) + 10'(cmdDwords);
          next_st.wordsLeft = CNT_W'((10'(cmdDwords) + 10'h007) >> 3);
          next_st.beatsLeft = CNT_W'((span + 10'h007) >> 3);
          next_st.lastDw    = 4'((span - 10'h001) & 10'h007) + 4'h1;
          next_st.carry     = '0;
          next_st.state     = PWS_DESC;
        end
      end

      // Start only when the whole payload is buffered so that
      // valid never gaps mid-packet; this caps length at 256 dwords.
      PWS_DESC: begin
        // whole payload buffered first
        // Trades buffer depth for a gap-free packet.
        if (slotFree && fifoLevel >= LVL_W'(needWords)) begin
          next_st.data = RST_DATA;
          next_st.data[63:DESC_ADDR_LSB] = st.addr[63:DESC_ADDR_LSB];
          next_st.data[DESC_DW_LSB +: DESC_DW_W] = DESC_DW_W'(st.dwords);
          next_st.data[DESC_TYPE_LSB +: 4] = REQ_MEM_WRITE;
          next_st.data[DESC_TAG_LSB +: 8]  = st.tag;
          next_st.keep  = '1;
          next_st.valid = 1'b1;
          next_st.last  = 1'b0;
          next_st.user  = side;
          next_st.state = PWS_PAY;
        end
      end

      // One payload beat per free slot
      PWS_PAY: begin
        if (slotFree) begin
          if (st.wordsLeft != '0) begin
            word    = fifoData;
            fifoPop = 1'b1;
            next_st.wordsLeft = st.wordsLeft - 1'b1;
          end
          // shift payload to its address dword
          pair     = {word, st.carry};
          shiftAmt = 9'h100 - {1'b0, st.off, 5'h00};
          pair     = pair >> shiftAmt;
          next_st.data  = pair[DATA_W-1:0];
          next_st.carry = word;
          next_st.valid = 1'b1;
          next_st.user  = side;
          next_st.keep  = '1;
          next_st.beatsLeft = st.beatsLeft - 1'b1;
          if (st.beatsLeft == CNT_W'(1)) begin
            next_st.last  = 1'b1;
            next_st.keep  = lastKeepMask;
            next_st.state = PWS_IDLE;
          end
        end
      end

      default: begin
        next_st.state = PWS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // reset clears valid, back to idle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st       <= '0;
      st.state <= PWS_IDLE;
      st.data  <= RST_DATA;
      st.keep  <= RST_KEEP;
      st.user  <= RST_USER;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  // sideband and keep driven
  assign cmdReady        = st.cmdReady;
  assign requestDataBus  = st.data;
  assign requestLastBeat = st.last;
  assign requestValidOut = st.valid;
  assign requestSideband = st.user;
  assign requestLaneKeep = st.keep;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic              firstBeat;  // Next beat opens a packet
  logic [KEEP_W:0]   keepPlus;   // Keep plus one, for contiguity

  assign keepPlus = {1'b0, st.keep} + (KEEP_W+1)'(1);

  // Tracks packet boundaries from handshakes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      firstBeat <= 1'b1;
    end else if (st.valid && requestReadyIn) begin
      firstBeat <= st.last;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  stallHold_a: assert property (st.valid && !requestReadyIn |=>
    st.valid && $stable(st.data) && $stable(st.user) && $stable(st.keep)
    && $stable(st.last))
    else $error("stalled beat changed");

  keepFull_a: assert property (st.valid && !st.last |-> st.keep == '1)
    else $error("keep not full on inner beat");

  keepContig_a: assert property (st.valid |->
    st.keep[0] && ((keepPlus[KEEP_W-1:0] & st.keep) == '0))
    else $error("keep has a gap");

  parityZero_a: assert property (st.valid |-> st.user[59:12] == '0)
    else $error("sideband reserved bits set");

  byteEnables_a: assert property (st.valid |-> st.user[7:0] == 8'hFF)
    else $error("byte enables not all ones");

  writeOnly_a: assert property (st.valid && firstBeat |->
    st.data[DESC_TYPE_LSB +: 4] == REQ_MEM_WRITE && !st.last)
    else $error("non-write descriptor");

  validHold_a: assert property (st.valid && requestReadyIn && !st.last
    |=> st.valid)
    else $error("valid gap inside packet");

  startOffset_a: assert property (st.valid && firstBeat |->
    st.user[10:8] == st.data[4:2])
    else $error("start offset mismatch");

  lastIdle_a: assert property (st.valid && st.last && requestReadyIn
    |=> firstBeat ##1 !(st.valid && st.last && firstBeat))
    else $error("packet end misframed");

  // pops only from a filled buffer
  // Guards the level test against a miscount
  popSafe_a: assert property (fifoPop |-> fifoValid)
    else $error("payload popped from empty buffer");

  // abort reaches every later beat
  // Checked on loads only; a beat already stalled keeps its old bit.
  abortFlag_a: assert property (st.state == PWS_PAY && slotFree && abortReq
    |=> st.user[USR_ABORT_BIT])
    else $error("nullify bit missing after abort");

endmodule : pws_framer

// file: test/pws_sink.sv
// Partner model: far-side request port, paces beats and records them.
module pws_sink (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic [pws_pkg::DATA_W-1:0] dataIn,
  input  wire logic                       lastIn,
  input  wire logic                       validIn,
  input  wire logic [pws_pkg::USER_W-1:0] userIn,
  input  wire logic [pws_pkg::KEEP_W-1:0] keepIn,
  input  wire logic                       stall,
  output logic                            readyOut,
  output int                              nBeats,
  output int                              nProtoErr
);
  timeunit 1ns;
  timeprecision 100ps;
  import pws_pkg::*;

  // ----------------------------------------------------------------
  // Capture store
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]               bData [64];  // Taken beat data
  logic [USER_W-1:0]               bUser [64];  // Taken beat sideband
  logic [KEEP_W-1:0]               bKeep [64];  // Taken beat keep
  logic                            bLast [64];  // Taken beat last flag
  logic [DATA_W+USER_W+KEEP_W:0]   held;        // Beat shown last cycle
  logic                            stalled;     // Last cycle valid, not ready
  logic                            inPkt;       // Packet under way
  logic [1:0]                      phase;       // Stall pattern step
  wire  [DATA_W+USER_W+KEEP_W:0]   cur = {dataIn, userIn, keepIn, lastIn};

  // Ready pacing, beat capture and stream watch
  always @(posedge clk_sys) begin
    if (rst) begin
      readyOut <= 1'b0;
      nBeats <= 0;
      nProtoErr <= 0;
      stalled <= 1'b0;
      inPkt <= 1'b0;
      phase <= 2'd0;
    end else begin
      phase <= phase + 2'd1;
      // with stall set, ready is low three cycles in four
      readyOut <= !stall || (phase == 2'd0);
      // beat counts only on valid with ready
      if (validIn && readyOut && nBeats < 64) begin
        bData[nBeats] <= dataIn;
        bUser[nBeats] <= userIn;
        bKeep[nBeats] <= keepIn;
        bLast[nBeats] <= lastIn;
        nBeats <= nBeats + 1;
        inPkt <= !lastIn;
      end
      // Gap inside a packet or a changed stalled beat is an error
      if ((inPkt && !validIn) || (stalled && (!validIn || cur !== held))) begin
        nProtoErr <= nProtoErr + 1;
      end
      stalled <= validIn && !readyOut;
      held <= cur;
    end
  end
endmodule : pws_sink

// file: test/tb_top.sv
// Testbench: feeds commands and payload, checks captured request beats.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pws_pkg::*;

  logic              clk_sys, rst, cmdValid, cmdReady, abortReq, wrValid, wrReady;
  logic              stall, reqLast, reqValid, reqReady;
  logic [63:0]       cmdAddr;
  logic [LEN_W-1:0]  cmdDwords;
  logic [7:0]        cmdTag;
  logic [DATA_W-1:0] wrData, reqData;
  logic [USER_W-1:0] reqUser;
  logic [KEEP_W-1:0] reqKeep;
  int                nMismatch, nCompared, nBeats, nProtoErr, cycles;

  pws_framer i_dut (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdAddr(cmdAddr), .cmdDwords(cmdDwords), .cmdTag(cmdTag), .abortReq(abortReq),
    .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady), .requestDataBus(reqData),
    .requestLastBeat(reqLast), .requestValidOut(reqValid), .requestSideband(reqUser),
    .requestLaneKeep(reqKeep), .requestReadyIn(reqReady));

  pws_sink i_sink (.clk_sys(clk_sys), .rst(rst), .dataIn(reqData), .lastIn(reqLast),
    .validIn(reqValid), .userIn(reqUser), .keepIn(reqKeep), .stall(stall),
    .readyOut(reqReady), .nBeats(nBeats), .nProtoErr(nProtoErr));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      wrapUp();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrapUp();
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrapUp

  // Push payload, offer command, then check every beat of the packet
  task automatic run_pkt(input logic [63:0] addr, input int len, input logic [7:0] tag,
                         input logic ab);
    int nw, off, nb, base, fin, idx;
    logic [DATA_W-1:0] w, e;
    logic [KEEP_W-1:0] k;
    nw = (len + 7) / 8;
    off = int'(addr[4:2]);
    nb = (off + len + 7) / 8;
    base = nBeats;
    fin = ((off + len - 1) % 8 + 1) * 4;
    k = (fin == 32) ? '1 : KEEP_W'((33'd1 << fin) - 33'd1);
    @(posedge clk_sys);
    abortReq <= ab;
    // Back-to-back payload words, dword i tagged with its index
    for (int i = 0; i < nw; i++) begin
      for (int d = 0; d < 8; d++) w[32*d +: 32] = {tag, 8'hC3, 16'(8*i+d)};
      wrData <= w;
      wrValid <= 1'b1;
      do @(posedge clk_sys); while (wrReady !== 1'b1);
    end
    wrValid <= 1'b0;
    @(posedge clk_sys);
    // A full buffer must refuse further words
    if (nw == FIFO_DEPTH) check("fifo full", DATA_W'(wrReady), '0);
    cmdAddr <= addr;
    cmdDwords <= LEN_W'(len);
    cmdTag <= tag;
    cmdValid <= 1'b1;
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    for (int c = 0; c < 3000 && nBeats < base + nb + 1; c++) @(posedge clk_sys);
    check("beat count", DATA_W'(nBeats), DATA_W'(base + nb + 1));
    e = '0;
    e[63:2] = addr[63:2];
    e[74:64] = 11'(len);
    e[78:75] = REQ_MEM_WRITE;
    e[103:96] = tag;
    check("descriptor", i_sink.bData[base], e);
    e = '0;
    e[7:0] = 8'hFF;
    e[10:8] = addr[4:2];
    e[11] = ab;
    for (int j = 0; j <= nb; j++) begin
      check("sideband", DATA_W'(i_sink.bUser[base+j]), e);
      check("keep", i_sink.bKeep[base+j], (j < nb) ? {KEEP_W{1'b1}} : k);
      check("last", DATA_W'(i_sink.bLast[base+j]), DATA_W'(j == nb));
      for (int d = 0; d < 8 && j > 0; d++) begin
        idx = 8 * (j - 1) + d - off;
        if (idx < len) begin
          w = '0;
          if (idx >= 0) w[31:0] = {tag, 8'hC3, 16'(idx)};
          check("payload dword", DATA_W'(i_sink.bData[base+j][32*d +: 32]), w);
        end
      end
    end
    check("drained", DATA_W'(wrReady), DATA_W'(1));
  endtask : run_pkt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [63:0] tAddr [5] = '{64'h1000, 64'h200C, 64'h1_0000_0014, 64'h4000, 64'h501C};
  int          tLen  [5] = '{8, 7, 20, 256, 1};
  logic        tAb   [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic        tStl  [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  initial begin
    rst = 1'b1;
    cmdValid = 1'b0;
    abortReq = 1'b0;
    wrValid = 1'b0;
    stall = 1'b0;
    cmdAddr = '0;
    cmdDwords = '0;
    cmdTag = '0;
    wrData = '0;
    repeat (6) @(posedge clk_sys);
    check("valid in reset", DATA_W'(reqValid), '0);
    check("cmd ready in reset", DATA_W'(cmdReady), '0);
    rst <= 1'b0;
    // Plain, offset, aborted, full-buffer and top-lane packets
    for (int t = 0; t < 5; t++) begin
      stall <= tStl[t];
      run_pkt(tAddr[t], tLen[t], 8'(8'h11 * (t + 1)), tAb[t]);
      $display("test %0d done", t);
    end
    check("stream holds", DATA_W'(nProtoErr), '0);
    wrapUp();
  end
endmodule : tb_top
